//--- logic/svd_pkg.sv
// Purpose: Constants for the supply voltage detection block.
// Assumes: 20 MHz core clock, plain 8-bit register port.
// Notes:   Each rule below except R10 and R11 is tagged where the logic carries it out.
// Overview of operation
// R01: Bit 0 write enables monitoring; reset clears.
// R02: Flags meaningful only 20 us after enable.
// R03: High flag bit 2 while above upper threshold.
// R04: Low flag bit 1 while below lower threshold.
// R05: Comparisons tracked continuously while enabled.
// R06: Enabled low flag sets request bit 5.
// R07: Request bit 5 holds until cleared or reset.
// R08: Request interrupts only when mask bit set.
// R09: Detection idle in stop mode; software disables.
// R10: Software enables interrupts before enabling detection.
// R11: Software keeps port mode steady while checking.
// R12: Disabled detection reads flags zero, no request; a request latched before disable stays set and readable.
package svd_pkg;

	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;

	// Register offsets.
	localparam logic [7:0]  CTRL_STAT_OFS   = 8'h0c;
	localparam logic [7:0]  IRQ_STAT_OFS    = 8'h10;
	localparam logic [7:0]  IRQ_CLEAR_OFS   = 8'h11;
	localparam logic [7:0]  IRQ_ENABLE_OFS  = 8'h12;

	// Field positions.
	localparam int          EN_BIT          = 0;
	localparam int          LOW_BIT         = 1;
	localparam int          HIGH_BIT        = 2;
	localparam int          REQ_BIT         = 5;

	// Reset values.
	localparam logic        EN_RST          = 1'b0;
	localparam logic        FLAG_RST        = 1'b0;
	localparam logic        REQ_RST         = 1'b0;
	localparam logic        MASK_RST        = 1'b0;

	// Settling time after enable.
	localparam int          CLK_PERIOD_NS   = 50;
	localparam int          SETTLE_TIME_NS  = 20000;
	localparam int          SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          SETTLE_W        = 9;
	localparam logic [8:0]  SETTLE_LOAD     = 9'(SETTLE_CYCLES);

endpackage

//--- logic/svd_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Inputs are slow levels; rst_n already released synchronously.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/10ps
module svd_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,      // Core clock.
	input  wire logic             rst_n,    // Active-low reset.
	input  wire logic [WIDTH-1:0] d_async,  // Asynchronous levels.
	output logic      [WIDTH-1:0] q_sync    // Synchronised levels.
);

	logic [WIDTH-1:0] meta_reg;

	// Two flip-flops in series, both cleared by reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q_sync   <= '0;
		end else begin
			meta_reg <= d_async;
			q_sync   <= meta_reg;
		end
	end

endmodule

//--- logic/svd_top.sv
// Purpose: Supply voltage detection flags, request latch and register port.
// Assumes: Comparator outputs are asynchronous levels; stop_mode is core logic.
// Notes:   Flags are forced low until detection has settled.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module svd_top
	import svd_pkg::*;
(
	input  wire logic              sys_clk,       // Core clock, 20 MHz.
	input  wire logic              rstn,          // Active-low asynchronous reset.
	input  wire logic [ADDR_W-1:0] addr,          // Register address.
	input  wire logic [DATA_W-1:0] wdata,         // Write data.
	input  wire logic              wr,            // Write strobe.
	input  wire logic              rd,            // Read strobe.
	output logic      [DATA_W-1:0] rdata,         // Read data, cycle after rd.
	input  wire logic              cmp_above_high, // Supply above upper threshold.
	input  wire logic              cmp_below_low, // Supply below lower threshold.
	input  wire logic              stop_mode,     // Core is in stop mode.
	output logic                   det_power_en,  // Powers the comparators.
	output logic                   irq            // Level interrupt.
);

	typedef struct packed {
		logic                en;
		logic [SETTLE_W-1:0] settle_cnt;
		logic [SETTLE_W:0]   on_cycles;
		logic                low;
		logic                high;
		logic                req;
		logic                mask;
		logic [DATA_W-1:0]   rdata;
	} svd_state_s;

	svd_state_s  state_reg;
	svd_state_s  state_next;
	logic        rst_meta_reg;
	logic        rst_sync_n;
	logic [1:0]  cmp_sync;
	logic        active;
	logic        settled;

	// Reset release through two flip-flops.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n   <= rst_meta_reg;
		end
	end

	// Comparator levels cross into the core clock.
	svd_sync #(
		.WIDTH   (2)
	) svd_sync_inst (
		.clk     (sys_clk),
		.rst_n   (rst_sync_n),
		.d_async ({cmp_above_high, cmp_below_low}),
		.q_sync  (cmp_sync)
	);

	// Detection runs only when enabled and out of stop mode.
	assign active       = state_reg.en && !stop_mode;          // [R09]
	assign settled      = active && (state_reg.settle_cnt == '0); // [R02]
	assign det_power_en = active;

	// Next-state logic for the whole block.
	always_comb begin
		state_next = state_reg;
		state_next.rdata = '0;
		// Register writes.
		if (wr) begin
			if (addr == CTRL_STAT_OFS) begin
				state_next.en = wdata[EN_BIT];                    // [R01]
			end else if (addr == IRQ_ENABLE_OFS) begin
				state_next.mask = wdata[REQ_BIT];
			end else if (addr == IRQ_CLEAR_OFS) begin
				if (wdata[REQ_BIT]) begin
					state_next.req = 1'b0;                        // [R07]
				end
			end
		end
		// Settling counter restarts whenever detection is idle.
		if (!active) begin
			state_next.settle_cnt = SETTLE_LOAD;                  // [R02]
		end else if (state_reg.settle_cnt != '0) begin
			state_next.settle_cnt = state_reg.settle_cnt - SETTLE_W'(1);
		end
		// Active cycles, saturating; only the settling checks read this count.
		if (!active) begin
			state_next.on_cycles = '0;
		end else if (!state_reg.on_cycles[SETTLE_W]) begin
			state_next.on_cycles = state_reg.on_cycles + (SETTLE_W+1)'(1);
		end
		// Flags follow the comparators every cycle once settled.
		state_next.high = settled && cmp_sync[1];                 // [R03] [R05] [R12]
		state_next.low  = settled && cmp_sync[0];                 // [R04] [R05] [R12]
		// A low flag sets the request; set wins over clear.
		if (state_reg.low) begin
			state_next.req = 1'b1;                                // [R06]
		end
		// Register reads.
		if (rd) begin
			if (addr == CTRL_STAT_OFS) begin
				state_next.rdata[EN_BIT]   = state_reg.en;
				state_next.rdata[LOW_BIT]  = state_reg.low;
				state_next.rdata[HIGH_BIT] = state_reg.high;
			end else if (addr == IRQ_STAT_OFS) begin
				state_next.rdata[REQ_BIT] = state_reg.req;
			end else if (addr == IRQ_ENABLE_OFS) begin
				state_next.rdata[REQ_BIT] = state_reg.mask;
			end
		end
	end

	// State register.
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg.en         <= EN_RST;
			state_reg.settle_cnt <= SETTLE_LOAD;
			state_reg.on_cycles  <= '0;
			state_reg.low        <= FLAG_RST;
			state_reg.high       <= FLAG_RST;
			state_reg.req        <= REQ_RST;
			state_reg.mask       <= MASK_RST;
			state_reg.rdata      <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs.
	assign rdata = state_reg.rdata;
	assign irq   = state_reg.req && state_reg.mask;             // [R08]

	// Assertions sample on the core clock and rest while reset is held.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_sync_n);

	// Switching detection on from the off state, out of stop mode.
	sequence s_switch_on;
		wr && (addr == CTRL_STAT_OFS) && wdata[EN_BIT] && !stop_mode && !state_reg.en;
	endsequence

	// Both flags stay low for a stretch of cycles.
	sequence s_quiet_flags;
		(!state_reg.low && !state_reg.high) [*8];
	endsequence

	// Any write to the control and status register.
	sequence s_ctrl_write;
		wr && (addr == CTRL_STAT_OFS);
	endsequence

	// Any read of the control and status register.
	sequence s_ctrl_read;
		rd && (addr == CTRL_STAT_OFS);
	endsequence

	// Detection has just become active, by enable or on leaving stop mode.
	sequence s_wake;
		$rose(active);
	endsequence

	// The settling counter is still running down.
	sequence s_settling;
		active && (state_reg.settle_cnt != '0);
	endsequence

	// Low comparator seen for one settled cycle and gone in the next.
	sequence s_low_pulse;
		settled && cmp_sync[0] ##1 settled && !cmp_sync[0];
	endsequence

	// A clear of the request with no low flag standing to set it again.
	sequence s_clear_alone;
		wr && (addr == IRQ_CLEAR_OFS) && wdata[REQ_BIT] && !state_reg.low;
	endsequence

	// A clear of the request that meets a standing low flag.
	sequence s_clear_clash;
		wr && (addr == IRQ_CLEAR_OFS) && wdata[REQ_BIT] && state_reg.low;
	endsequence

	// A write that masks the request off.
	sequence s_mask_off;
		wr && (addr == IRQ_ENABLE_OFS) && !wdata[REQ_BIT];
	endsequence

	// Detection off with nothing latched.
	sequence s_off_clean;
		!state_reg.en && !state_reg.low && !state_reg.req;
	endsequence

	// The enable bit takes the written value in the next cycle.
	property p_enable_write;
		s_ctrl_write |=> state_reg.en == $past(wdata[EN_BIT]);
	endproperty

	// A read returns the enable bit as it stood at the strobe.
	property p_read_enable;
		s_ctrl_read |=> rdata[EN_BIT] == $past(state_reg.en);
	endproperty

	// A read returns both flags as they stood at the strobe.
	property p_read_flags;
		s_ctrl_read |=> (rdata[LOW_BIT] == $past(state_reg.low))
			&& (rdata[HIGH_BIT] == $past(state_reg.high));
	endproperty

	// No flag may rise in the first cycles after switching on.
	property p_settle_quiet;
		s_switch_on |=> s_quiet_flags;
	endproperty

	// Each active cycle with the counter above zero takes one step off the settling counter.
	property p_settle_step;
		s_settling |=> state_reg.settle_cnt == $past(state_reg.settle_cnt) - SETTLE_W'(1);
	endproperty

	// Flags stay low while the counter still runs.
	property p_settle_gate;
		state_reg.settle_cnt != '0 |=> !state_reg.low && !state_reg.high;
	endproperty

	// A raised flag means the block has been active for the whole settling time.
	property p_settle_time;
		state_reg.low || state_reg.high |-> state_reg.on_cycles > (SETTLE_W+1)'(SETTLE_CYCLES);
	endproperty

	// A comparator pulse that ends must clear the low flag again.
	property p_low_follow;
		s_low_pulse |=> !state_reg.low;
	endproperty

	// The request holds until a write to the clear register.
	property p_req_hold;
		state_reg.req && !(wr && (addr == IRQ_CLEAR_OFS)) |=> state_reg.req;
	endproperty

	// Stop mode cuts comparator power at once and the flags a cycle later.
	property p_stop_idle;
		stop_mode |-> !det_power_en ##1 (!state_reg.low && !state_reg.high);
	endproperty

	// With detection off and nothing latched, no request appears.
	property p_off_request;
		s_off_clean |=> !state_reg.req;
	endproperty

	// Enable bit written and read back.
	a_enable_write: assert property (p_enable_write) // [R01]
		else $error("Enable bit did not take the written value.");
	a_read_enable: assert property (p_read_enable) // [R01]
		else $error("Enable bit read back wrong.");

	// Settling window after detection starts.
	a_settle_quiet: assert property (p_settle_quiet) // [R02]
		else $error("Flag set before the settling time ran out.");
	a_settle_load: assert property (s_wake |-> state_reg.settle_cnt == SETTLE_LOAD) // [R02]
		else $error("Settling counter not loaded on wake.");
	a_settle_step: assert property (p_settle_step) // [R02]
		else $error("Settling counter did not step down.");
	a_settle_gate: assert property (p_settle_gate) // [R02]
		else $error("Flag set while settling counter ran.");
	a_settle_time: assert property (p_settle_time) // [R02]
		else $error("Flag set before full settling time.");

	// Flags track the synchronised comparators once settled, and read back as they stood at the strobe.
	a_high_track: assert property (settled && cmp_sync[1] |=> state_reg.high) // [R03]
		else $error("High flag missed an above-threshold supply.");
	a_high_clear: assert property (settled && !cmp_sync[1] |=> !state_reg.high) // [R05]
		else $error("High flag stayed without an above-threshold supply.");
	a_low_track: assert property (settled && !cmp_sync[0] |=> !state_reg.low) // [R04]
		else $error("Low flag set with supply above threshold.");
	a_low_set: assert property (settled && cmp_sync[0] |=> state_reg.low) // [R04]
		else $error("Low flag missed a below-threshold supply.");
	a_read_flags: assert property (p_read_flags) // [R04]
		else $error("Flags read back wrong.");
	a_low_follow: assert property (p_low_follow) // [R05]
		else $error("Low flag did not follow the comparator.");

	// Request latch, clear and mask.
	a_req_set: assert property (state_reg.low |=> state_reg.req) // [R06]
		else $error("Low flag did not set the request.");
	a_req_hold: assert property (p_req_hold) // [R07]
		else $error("Request dropped without a clear.");
	a_clear_alone: assert property (s_clear_alone |=> !state_reg.req) // [R07]
		else $error("Request survived a clear.");
	a_set_wins: assert property (s_clear_clash |=> state_reg.req) // [R07]
		else $error("Clear won over a standing low flag.");
	a_irq_gate: assert property (irq |-> state_reg.mask && state_reg.req) // [R08]
		else $error("Interrupt raised while masked.");
	a_mask_off: assert property (s_mask_off |=> !irq) // [R08]
		else $error("Interrupt stayed after masking.");

	// Stop mode and disabled detection.
	a_stop_idle: assert property (p_stop_idle) // [R09]
		else $error("Detection active in stop mode.");
	a_off_zero: assert property (!state_reg.en |=> !state_reg.low && !state_reg.high) // [R12]
		else $error("Flags set while detection disabled.");
	a_off_request: assert property (p_off_request) // [R12]
		else $error("Request raised while detection disabled.");

endmodule

//--- dv/svd_supply_model.sv
// Purpose: Behavioural supply level and threshold comparators.
// Assumes: Supply is given as an 8-bit level code.
// Notes:   Unpowered comparators rest low.
`timescale 1ns/10ps
module svd_supply_model #(
	parameter logic [7:0] HI_LVL = 8'hc0, // Upper threshold code.
	parameter logic [7:0] LO_LVL = 8'h40  // Lower threshold code.
) (
	input  wire logic [7:0] level,   // Supply level code.
	input  wire logic       powered, // Comparator power.
	output logic            above,   // Above upper threshold.
	output logic            below    // Below lower threshold.
);
	// Outputs carry no port switching noise; port mode never moves.
	// Comparators follow the supply at once and drop when unpowered.
	assign above = powered && (level > HI_LVL);
	assign below = powered && (level < LO_LVL);
endmodule

//--- dv/svd_top_tb.sv
// Purpose: Self-checking bench for the supply detection block.
// Assumes: Thresholds 8'hc0 and 8'h40 in the supply model.
// Notes:   Reads note {irq, rdata} in a queue for the checker.
`timescale 1ns/10ps
module svd_top_tb;
	import svd_pkg::*;
	logic       sys_clk = 0, rstn = 0, wr = 0, rd = 0, stop_mode = 0, rd_q = 0;
	logic [7:0] addr = 0, wdata = 0, level = 8'h80, rdata;
	logic       above, below, det_power_en, irq;
	logic [8:0] notes[$];
	int         failures = 0, comparisons = 0;
	// Clock of 50 ns period.
	always #25 sys_clk = ~sys_clk;
	svd_supply_model svd_supply_model_inst (.level(level), .powered(det_power_en),
		.above(above), .below(below));
	svd_top svd_top_inst (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .cmp_above_high(above), .cmp_below_low(below),
		.stop_mode(stop_mode), .det_power_en(det_power_en), .irq(irq));
	task check(input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task put(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task get(input logic [7:0] a, input logic [8:0] e);
		notes.push_back(e);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Sets the supply, lets the flags settle, then reads them with the interrupt.
	task sense(input logic [7:0] lv, input logic ie);
		level <= lv;
		repeat (6) @(posedge sys_clk);
		get(CTRL_STAT_OFS, {ie, 5'h00, lv > 8'hc0, lv < 8'h40, 1'b1});
	endtask
	// Matches each read result against the oldest note.
	always @(posedge sys_clk) begin
		if (rd_q)
			check({irq, rdata}, notes.pop_front());
		rd_q <= rd;
	end
	// Main sequence.
	initial begin
		void'($urandom(32'hd6b3));
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		get(CTRL_STAT_OFS, 9'h000);
		get(IRQ_ENABLE_OFS, 9'h000);
		get(8'h20, 9'h000);
		level <= 8'h10;
		repeat (6) @(posedge sys_clk);
		get(CTRL_STAT_OFS, 9'h000);
		get(IRQ_STAT_OFS, 9'h000);
		put(IRQ_ENABLE_OFS, 8'h20);
		put(CTRL_STAT_OFS, 8'h01);
		check({8'h00, det_power_en}, 9'h001);
		repeat (6) @(posedge sys_clk);
		get(CTRL_STAT_OFS, 9'h001);
		level <= 8'h80;
		repeat (SETTLE_CYCLES) @(posedge sys_clk);
		sense(8'h80, 1'b0);
		sense(8'hf0, 1'b0);
		sense(8'h10, 1'b1);
		sense(8'h80, 1'b1);
		get(IRQ_STAT_OFS, 9'h120);
		put(IRQ_CLEAR_OFS, 8'h20);
		get(IRQ_STAT_OFS, 9'h000);
		put(IRQ_ENABLE_OFS, 8'h00);
		sense(8'h10, 1'b0);
		sense(8'h80, 1'b0);
		get(IRQ_STAT_OFS, 9'h020);
		put(IRQ_CLEAR_OFS, 8'h20);
		stop_mode <= 1'b1;
		level <= 8'h10;
		repeat (6) @(posedge sys_clk);
		check({8'h00, det_power_en}, 9'h000);
		get(CTRL_STAT_OFS, 9'h001);
		get(IRQ_STAT_OFS, 9'h000);
		level <= 8'h80;
		stop_mode <= 1'b0;
		repeat (SETTLE_CYCLES + 2) @(posedge sys_clk);
		repeat (8) sense(8'($urandom), 1'b0);
		level <= 8'h10;
		repeat (6) @(posedge sys_clk);
		put(CTRL_STAT_OFS, 8'h00);
		get(CTRL_STAT_OFS, 9'h000);
		get(IRQ_STAT_OFS, 9'h020);
		conclude;
	end
	// Watchdog far beyond the expected run of about 1000 cycles.
	initial begin
		repeat (3000) @(posedge sys_clk);
		failures++;
		conclude;
	end
endmodule
